// ### include/psfrc_pkg.sv
// Constants for the power stage fault and reset controller.
// Assumes a single 200 MHz system clock.
package psfrc_pkg;
   // ************************************************************
   // Clock and timing
   // ************************************************************
   localparam int unsigned CLK_HZ = 200_000_000;
   localparam int unsigned OVLD_TIME_US = 2600;
   localparam int unsigned OVLD_CYCLES = (CLK_HZ / 1_000_000) * OVLD_TIME_US;
   localparam int unsigned PWM_TIMEOUT_NS = 10_000;
   localparam int unsigned PWM_TIMEOUT_CYCLES = PWM_TIMEOUT_NS / 5;
   localparam int unsigned STARTUP_NS = 1_000;
   localparam int unsigned STARTUP_CYCLES = STARTUP_NS / 5;
   localparam int unsigned NUM_CH = 4;
   localparam int unsigned CNT_W = 20;
   // ************************************************************
   // Overcurrent modes
   // ************************************************************
   localparam logic OC_MODE_LIMIT = 1'b0;
   localparam logic OC_MODE_LATCH = 1'b1;
endpackage

// ### rtl/psfrc_channel.sv
// One half-bridge channel: PWM presence, overcurrent handling, gate drive.
// Assumes inputs already synchronised to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module psfrc_channel #(
   parameter int unsigned OVLD_CYC = psfrc_pkg::OVLD_CYCLES,
   parameter int unsigned PWM_TO_CYC = psfrc_pkg::PWM_TIMEOUT_CYCLES
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic run_i,
   input wire logic clear_i,
   input wire logic oc_mode_i,
   input wire logic pwm_i,
   input wire logic overcurrent_i,
   input wire logic half_rate_i,
   output logic out_o,
   output logic drive_en_o,
   output logic pwm_lost_o,
   output logic overload_shutdown_o,
   output logic oc_latched_o
);
   import psfrc_pkg::*;
   if (OVLD_CYC < 1 || OVLD_CYC >= (1 << CNT_W))
   begin
      $error("OVLD_CYC out of range");
   end
   if (PWM_TO_CYC < 1 || PWM_TO_CYC >= (1 << CNT_W))
   begin
      $error("PWM_TO_CYC out of range");
   end
   logic pwm_q;
   logic [CNT_W-1:0] idle_q;
   logic [CNT_W-1:0] ovld_q;
   logic pwm_lost_q;
   logic ovld_f_q;
   logic ocl_q;
   logic flip_q;
   logic out_q;
   logic cycle_current_limit;
   // ************************************************************
   // PWM presence
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      pwm_q <= rst_i ? 1'b0 : pwm_i;
      if (rst_i || pwm_i != pwm_q)
      begin
         idle_q <= '0;
         pwm_lost_q <= 1'b0;
      end
      else if (idle_q != PWM_TO_CYC[CNT_W-1:0])
         idle_q <= idle_q + 1'b1;
      else
         pwm_lost_q <= 1'b1;
   end
   assign cycle_current_limit = overcurrent_i && oc_mode_i == OC_MODE_LIMIT;
   // ************************************************************
   // Overload and latched overcurrent
   // ************************************************************
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || clear_i || !cycle_current_limit)
         ovld_q <= '0;
      else if (ovld_q != OVLD_CYC[CNT_W-1:0])
         ovld_q <= ovld_q + 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || clear_i)
         ovld_f_q <= 1'b0;
      else if (ovld_q == OVLD_CYC[CNT_W-1:0])
         ovld_f_q <= 1'b1;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || clear_i)
         ocl_q <= 1'b0;
      else if (overcurrent_i && oc_mode_i == OC_MODE_LATCH)
         ocl_q <= 1'b1;
   end
   // ************************************************************
   // Output stage
   // ************************************************************
   // Limiting toggles at half the switching rate instead of following PWM
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         flip_q <= 1'b0;
      else if (cycle_current_limit && half_rate_i)
         flip_q <= ~flip_q;
   end
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i)
         out_q <= 1'b0;
      else if (cycle_current_limit)
         out_q <= flip_q;
      else
         out_q <= ~pwm_q;
   end
   assign out_o = out_q;
   assign drive_en_o = run_i && !pwm_lost_q && !ovld_f_q && !ocl_q;
   assign pwm_lost_o = pwm_lost_q;
   assign overload_shutdown_o = ovld_f_q;
   assign oc_latched_o = ocl_q;
endmodule
`default_nettype wire

// ### rtl/psfrc_top.sv
// Fault supervision and reset control for a four half-bridge power stage.
// Assumes comparator and reset inputs are asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module psfrc_top #(
   parameter int unsigned OVLD_CYC = psfrc_pkg::OVLD_CYCLES,
   parameter int unsigned PWM_TO_CYC = psfrc_pkg::PWM_TIMEOUT_CYCLES,
   parameter int unsigned START_CYC = psfrc_pkg::STARTUP_CYCLES,
   parameter int unsigned HALF_DIV = 2
)(
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic reset_n_i,
   input wire logic bridge_tied_mode_i,
   input wire logic oc_latch_mode_i,
   input wire logic thermal_warn_i,
   input wire logic thermal_shutdown_event_i,
   input wire logic loop_saturated_i,
   input wire logic [psfrc_pkg::NUM_CH-1:0] pwm_i,
   input wire logic [psfrc_pkg::NUM_CH-1:0] overcurrent_i,
   output logic [psfrc_pkg::NUM_CH-1:0] out_o,
   output logic [psfrc_pkg::NUM_CH-1:0] out_oe_o,
   output logic [psfrc_pkg::NUM_CH-1:0] pulldown_en_o,
   output logic fault_n_o,
   output logic fault_n_oe_o,
   output logic thermal_warning_n_o,
   output logic thermal_warning_n_oe_o,
   output logic saturation_warning_n_o,
   output logic saturation_warning_n_oe_o,
   output logic switching_o
);
   import psfrc_pkg::*;
   if (START_CYC < 1 || START_CYC >= (1 << CNT_W))
   begin
      $error("START_CYC out of range");
   end
   if (HALF_DIV < 1 || HALF_DIV >= (1 << CNT_W))
   begin
      $error("HALF_DIV out of range");
   end
   typedef enum logic [2:0]
   {
      ST_HOLD = 3'b001,
      ST_START = 3'b010,
      ST_RUN = 3'b100
   } psfrc_state_e;
   // ************************************************************
   // Input synchronisers
   // ************************************************************
   localparam int unsigned SW = 6 + 2 * NUM_CH;
   logic [SW-1:0] s1_q;
   logic [SW-1:0] s2_q;
   always_ff @(posedge sys_clk_i)
   begin
      s1_q <= {reset_n_i, bridge_tied_mode_i, oc_latch_mode_i, thermal_warn_i,
               thermal_shutdown_event_i, loop_saturated_i, pwm_i, overcurrent_i};
      s2_q <= s1_q;
   end
   logic rstn_s, bt_s, ocm_s, tw_s, tsd_s, sat_s;
   logic [NUM_CH-1:0] pwm_s;
   logic [NUM_CH-1:0] oc_s;
   assign {rstn_s, bt_s, ocm_s, tw_s, tsd_s, sat_s, pwm_s, oc_s} = s2_q;
   logic rstn_q;
   always_ff @(posedge sys_clk_i)
      rstn_q <= rst_i ? 1'b0 : rstn_s;
   logic rise;
   assign rise = rstn_s && !rstn_q;
   // ************************************************************
   // Startup sequencing
   // ************************************************************
   psfrc_state_e state_q;
   logic [CNT_W-1:0] start_q;
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || !rstn_s)
      begin
         state_q <= ST_HOLD;
         start_q <= '0;
      end
      else
      begin
         unique case (state_q)
            ST_HOLD:
            begin
               if (rise)
                  state_q <= ST_START;
            end
            ST_START:
            begin
               if (start_q == START_CYC[CNT_W-1:0] - 1'b1)
                  state_q <= ST_RUN;
               else
                  start_q <= start_q + 1'b1;
            end
            ST_RUN:
            begin
               state_q <= ST_RUN;
            end
            default:
            begin
               state_q <= ST_HOLD;
            end
         endcase
      end
   end
   logic run;
   assign run = state_q == ST_RUN;
   // Latches clear on the held-low level so a fault cannot survive a toggle
   logic clear;
   assign clear = !rstn_s;
   // ************************************************************
   // Thermal shutdown latch
   // ************************************************************
   logic thermal_shutdown_latch_q;
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || clear)
         thermal_shutdown_latch_q <= 1'b0;
      else if (tsd_s)
         thermal_shutdown_latch_q <= 1'b1;
   end
   // ************************************************************
   // Half switching rate enable
   // ************************************************************
   logic [CNT_W-1:0] div_q;
   logic half_rate;
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || div_q == HALF_DIV[CNT_W-1:0] - 1'b1)
         div_q <= '0;
      else
         div_q <= div_q + 1'b1;
   end
   assign half_rate = div_q == '0;
   // ************************************************************
   // Channels
   // ************************************************************
   logic [NUM_CH-1:0] ch_out;
   logic [NUM_CH-1:0] ch_en;
   logic [NUM_CH-1:0] ch_lost;
   logic [NUM_CH-1:0] ch_ovld;
   logic [NUM_CH-1:0] ch_ocl;
   genvar g;
   generate
      for (g = 0; g < NUM_CH; g++)
      begin : g_ch
         psfrc_channel #(
            .OVLD_CYC(OVLD_CYC),
            .PWM_TO_CYC(PWM_TO_CYC)
         ) u_ch (
            .sys_clk_i(sys_clk_i),
            .rst_i(rst_i),
            .run_i(run),
            .clear_i(clear),
            .oc_mode_i(ocm_s),
            .pwm_i(pwm_s[g]),
            .overcurrent_i(oc_s[g]),
            .half_rate_i(half_rate),
            .out_o(ch_out[g]),
            .drive_en_o(ch_en[g]),
            .pwm_lost_o(ch_lost[g]),
            .overload_shutdown_o(ch_ovld[g]),
            .oc_latched_o(ch_ocl[g])
         );
      end
   endgenerate
   // ************************************************************
   // Outputs
   // ************************************************************
   logic all_lost;
   assign all_lost = &ch_lost;
   always_ff @(posedge sys_clk_i)
   begin
      out_o <= rst_i ? '0 : ch_out;
      out_oe_o <= (rst_i || thermal_shutdown_latch_q || all_lost) ? '0 : ch_en;
      pulldown_en_o <= (!rst_i && !rstn_s && bt_s) ? '1 : '0;
   end
   logic fault_q;
   always_ff @(posedge sys_clk_i)
   begin
      if (rst_i || !rstn_s)
         fault_q <= 1'b0;
      else
         fault_q <= thermal_shutdown_latch_q || (|ch_ovld) || (|ch_ocl);
   end
   logic tw_q;
   logic sat_q;
   always_ff @(posedge sys_clk_i)
   begin
      tw_q <= rst_i ? 1'b0 : tw_s;
      sat_q <= rst_i ? 1'b0 : (sat_s && run);
   end
   // Open drain: output low only, enable set while pulling
   assign fault_n_o = 1'b0;
   assign fault_n_oe_o = fault_q;
   assign thermal_warning_n_o = 1'b0;
   assign thermal_warning_n_oe_o = tw_q;
   assign saturation_warning_n_o = 1'b0;
   assign saturation_warning_n_oe_o = sat_q;
   assign switching_o = run;
endmodule
`default_nettype wire

// ### verification/psfrc_ctrl_model.sv
// Controller model: drives the device reset pin and four PWM streams.
// Assumes the fault pin enable is high while the pin is pulled low.
`timescale 1ns/1ps
`default_nettype none
module psfrc_ctrl_model #(
   parameter int unsigned HOLD_CYC = 40
)(
   input wire logic sys_clk_i,
   input wire logic release_i,
   input wire logic [3:0] stop_i,
   input wire logic fault_n_oe_i,
   output logic reset_n_o,
   output logic [3:0] pwm_o
);
   // ************************************************************
   // Reset pin and PWM streams
   // ************************************************************
   logic rn_q = 1'b0;
   logic fault_q = 1'b0;
   logic [3:0] pwm_q = 4'h0;
   logic [2:0] tick_q = 3'h0;
   int unsigned since_q = HOLD_CYC;
   assign reset_n_o = rn_q;
   assign pwm_o = pwm_q;
   always @(posedge sys_clk_i)
   begin
      fault_q <= fault_n_oe_i;
      if (fault_n_oe_i && !fault_q)
         since_q <= 0;
      else if (since_q < HOLD_CYC)
         since_q <= since_q + 1;
      if (!release_i)
         rn_q <= 1'b0;
      else if (since_q >= HOLD_CYC)
         rn_q <= 1'b1;
      tick_q <= tick_q + 3'h1;
      // Stopped channels hold their level, as a stuck modulator would
      if (tick_q == 3'h7)
         pwm_q <= pwm_q ^ ~stop_i;
   end
endmodule
`default_nettype wire

// ### verification/psfrc_monitor.sv
// Port checker for the power stage fault controller.
// Assumes START_CYC near 4 and the two-flop input synchronisers.
`timescale 1ns/1ps
`default_nettype none
module psfrc_monitor (
   input wire logic sys_clk_i,
   input wire logic rst_i,
   input wire logic reset_n_i,
   input wire logic bridge_tied_mode_i,
   input wire logic thermal_warn_i,
   input wire logic thermal_shutdown_event_i,
   input wire logic loop_saturated_i,
   input wire logic [psfrc_pkg::NUM_CH-1:0] pwm_i,
   input wire logic [psfrc_pkg::NUM_CH-1:0] overcurrent_i,
   input wire logic [psfrc_pkg::NUM_CH-1:0] out_o,
   input wire logic [psfrc_pkg::NUM_CH-1:0] out_oe_o,
   input wire logic [psfrc_pkg::NUM_CH-1:0] pulldown_en_o,
   input wire logic fault_n_oe_o,
   input wire logic thermal_warning_n_oe_o,
   input wire logic saturation_warning_n_oe_o,
   input wire logic switching_o
);
   // ************************************************************
   // Properties
   // ************************************************************
   default clocking @(posedge sys_clk_i); endclocking
   default disable iff (rst_i);
   // Five cycles covers synchroniser, state and output register
   sequence held_low_s; !reset_n_i[*5]; endsequence
   sequence released_s; $rose(reset_n_i) ##0 !switching_o; endsequence
   sequence quiet_pwm_s; ($stable(pwm_i[0]) && !overcurrent_i[0])[*5]; endsequence
   // Strap goes through the synchroniser, so compare with its value three cycles back
   sequence strap_set_s; $past(bridge_tied_mode_i, 3) == bridge_tied_mode_i; endsequence
   reset_hiz_a: assert property (held_low_s |-> out_oe_o == '0)
      else $error("bridge driven while reset low");
   pulldown_mode_a: assert property (held_low_s ##0 strap_set_s |->
      pulldown_en_o == {psfrc_pkg::NUM_CH{bridge_tied_mode_i}})
      else $error("pulldown does not match output mode");
   fault_release_a: assert property (held_low_s |-> !fault_n_oe_o)
      else $error("fault shown while reset low");
   thermal_off_a: assert property (
      (thermal_shutdown_event_i && reset_n_i)[*4] |-> ##[0:3] (fault_n_oe_o && out_oe_o == '0))
      else $error("thermal shutdown not applied");
   fault_hold_a: assert property (
      reset_n_i[*4] ##0 fault_n_oe_o |=> fault_n_oe_o)
      else $error("fault cleared without reset");
   warn_follow_a: assert property (
      $stable(thermal_warn_i)[*5] |-> thermal_warning_n_oe_o == thermal_warn_i)
      else $error("warning pin does not follow temperature");
   saturation_warning_n_flag_a: assert property (
      (loop_saturated_i && switching_o)[*5] |-> saturation_warning_n_oe_o)
      else $error("saturation_warning_n not shown");
   invert_out_a: assert property (quiet_pwm_s ##0 out_oe_o[0] |-> out_o[0] == !pwm_i[0])
      else $error("output not inverted");
   startup_run_a: assert property (released_s |-> ##[5:14] switching_o)
      else $error("switching did not start");
endmodule
`default_nettype wire
bind psfrc_top psfrc_monitor i_psfrc_monitor (.sys_clk_i, .rst_i, .reset_n_i,
   .bridge_tied_mode_i, .thermal_warn_i, .thermal_shutdown_event_i, .loop_saturated_i,
   .pwm_i, .overcurrent_i, .out_o, .out_oe_o, .pulldown_en_o, .fault_n_oe_o,
   .thermal_warning_n_oe_o, .saturation_warning_n_oe_o, .switching_o);

// ### verification/psfrc_top_tb.sv
// Bench for the power stage fault controller with a controller model.
// Assumes shortened counts: overload 50, PWM timeout 20, startup 4.
`timescale 1ns/1ps
`default_nettype none
module psfrc_top_tb;
   // ************************************************************
   // Stimulus and checks
   // ************************************************************
   logic sys_clk_i = 1'b0, rst_i, rel, bridge_tied_mode_i, oc_latch_mode_i, thermal_warn_i;
   logic thermal_shutdown_event_i, loop_saturated_i, reset_n_i, fault_n_oe_o;
   logic thermal_warning_n_oe_o, saturation_warning_n_oe_o, switching_o;
   logic [3:0] stop, overcurrent_i, pwm_i, out_o, out_oe_o, pulldown_en_o;
   logic a, b, c;
   logic fault_n_o, thermal_warning_n_o, saturation_warning_n_o;
   int n_errors = 0, n_checks = 0, cyc = 0;
   always #2.5 sys_clk_i = ~sys_clk_i;
   psfrc_top #(.OVLD_CYC(50), .PWM_TO_CYC(20), .START_CYC(4)) i_psfrc_top (.sys_clk_i,
      .rst_i, .reset_n_i, .bridge_tied_mode_i, .oc_latch_mode_i, .thermal_warn_i,
      .thermal_shutdown_event_i, .loop_saturated_i, .pwm_i, .overcurrent_i, .out_o,
      .out_oe_o, .pulldown_en_o, .fault_n_o, .fault_n_oe_o, .thermal_warning_n_o,
      .thermal_warning_n_oe_o, .saturation_warning_n_o, .saturation_warning_n_oe_o,
      .switching_o);
   psfrc_ctrl_model #(.HOLD_CYC(40)) i_psfrc_ctrl_model (.sys_clk_i, .release_i(rel),
      .stop_i(stop), .fault_n_oe_i(fault_n_oe_o), .reset_n_o(reset_n_i), .pwm_o(pwm_i));
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk_i);
      #1;
   endtask
   task automatic chk4(input string nm, input logic [3:0] e, input logic [3:0] g);
      n_checks++;
      if (g !== e)
      begin
         n_errors++;
         $display("BAD %s exp %h got %h", nm, e, g);
      end
   endtask
   task automatic chk1(input string nm, input logic e, input logic g);
      chk4(nm, {3'h0, e}, {3'h0, g});
   endtask
   task automatic complete_run();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   // Bounded wait: a stuck start-up shows as a mismatch, not a hang
   task automatic wait_run();
      int i;
      i = 0;
      while (switching_o !== 1'b1 && i < 100)
      begin
         tick(1);
         i++;
      end
      chk1("switching", 1'b1, switching_o);
      tick(12);
      chk4("oe run", 4'hF, out_oe_o);
   endtask
   task automatic reset_cycle();
      rel = 1'b0;
      tick(8);
      chk1("fault low rst", 1'b0, fault_n_oe_o);
      chk4("oe low rst", 4'h0, out_oe_o);
      rel = 1'b1;
      wait_run();
   endtask
   always @(posedge sys_clk_i)
   begin
      cyc++;
      if (cyc == 5000)
      begin
         n_errors++;
         complete_run();
      end
   end
   initial
   begin
      rst_i = 1'b1; rel = 1'b0; stop = 4'h0; bridge_tied_mode_i = 1'b1;
      oc_latch_mode_i = 1'b0; thermal_warn_i = 1'b0; thermal_shutdown_event_i = 1'b0;
      loop_saturated_i = 1'b0; overcurrent_i = 4'h0;
      tick(6);
      rst_i = 1'b0;
      tick(6);
      chk4("oe held", 4'h0, out_oe_o);
      chk4("pulldown bt", 4'hF, pulldown_en_o);
      chk1("fault held", 1'b0, fault_n_oe_o);
      bridge_tied_mode_i = 1'b0;
      tick(3);
      chk4("pulldown single", 4'h0, pulldown_en_o);
      bridge_tied_mode_i = 1'b1;
      rel = 1'b1;
      wait_run();
      chk1("fault pin", 1'b0, fault_n_o);
      chk1("warn pin", 1'b0, thermal_warning_n_o);
      chk1("saturation_warning_n pin", 1'b0, saturation_warning_n_o);
      repeat (2)
      begin
         @(pwm_i[0]);
         tick(5);
         chk4("invert", ~pwm_i, out_o);
      end
      thermal_warn_i = 1'b1;
      loop_saturated_i = 1'b1;
      tick(6);
      chk1("warn on", 1'b1, thermal_warning_n_oe_o);
      chk1("run warn", 1'b1, switching_o);
      chk1("saturation_warning_n on", 1'b1, saturation_warning_n_oe_o);
      thermal_warn_i = 1'b0;
      loop_saturated_i = 1'b0;
      tick(6);
      chk1("warn off", 1'b0, thermal_warning_n_oe_o);
      chk1("saturation_warning_n off", 1'b0, saturation_warning_n_oe_o);
      for (int i = 3; i >= 0; i--)
      begin
         stop = (i == 3) ? 4'hF : 4'h1 << i;
         tick(40);
         chk4("oe lost", ~stop, out_oe_o);
         chk1("fault lost", 1'b0, fault_n_oe_o);
         stop = 4'h0;
         tick(30);
         chk4("oe back", 4'hF, out_oe_o);
      end
      overcurrent_i = 4'h2;
      tick(10);
      chk1("fault limit", 1'b0, fault_n_oe_o);
      a = out_o[1];
      tick(1);
      b = out_o[1];
      tick(1);
      c = out_o[1];
      chk1("flip", 1'b1, (a !== b) || (b !== c));
      tick(60);
      chk4("oe overload", 4'hD, out_oe_o);
      chk1("fault overload", 1'b1, fault_n_oe_o);
      overcurrent_i = 4'h0;
      tick(10);
      chk1("fault kept", 1'b1, fault_n_oe_o);
      reset_cycle();
      oc_latch_mode_i = 1'b1;
      tick(3);
      overcurrent_i = 4'h8;
      tick(4);
      overcurrent_i = 4'h0;
      tick(6);
      chk4("oe latched", 4'h7, out_oe_o);
      chk1("fault latched", 1'b1, fault_n_oe_o);
      reset_cycle();
      thermal_shutdown_event_i = 1'b1;
      tick(4);
      thermal_shutdown_event_i = 1'b0;
      tick(6);
      chk4("oe thermal", 4'h0, out_oe_o);
      chk1("fault thermal", 1'b1, fault_n_oe_o);
      reset_cycle();
      complete_run();
   end
endmodule
`default_nettype wire
